// [cts_decode.sv]
/*
 * Turns the stored setting codes into analog targets in mV and mA.
 * Assumes codes come from registers on the same clock; outputs are registered.
 */
`timescale 1ns/100ps
`include "cts_regs.svh"

module cts_decode (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // codes
    input wire logic [5:0] float_voltage_code,
    input wire logic [1:0] charge_voltage_ceiling,
    input wire logic [3:0] fast_current_code,
    input wire logic [1:0] trickle_current_code,
    input wire logic recharge_off,
    input wire logic [1:0] recharge_delta_code,
    input wire logic [1:0] dead_battery_threshold,
    input wire logic [2:0] weak_battery_threshold,
    // targets
    output logic [12:0] float_mv,
    output logic [12:0] ceil_mv,
    output logic [10:0] fast_ma,
    output logic [6:0] trickle_ma,
    output logic recharge_en,
    output logic [8:0] recharge_delta_mv,
    output logic [11:0] dead_mv,
    output logic [11:0] weak_mv
);
    logic [12:0] float_lin;
    logic [12:0] float_knee;
    logic [12:0] nxt_float;
    logic [12:0] nxt_ceil;
    logic [10:0] nxt_fast;
    logic [6:0] nxt_trk;
    logic [11:0] nxt_dead;

    assign float_lin = 13'(`CTS_FLOAT_BASE_MV + `CTS_FLOAT_STEP_MV * 13'(float_voltage_code));
    assign float_knee = 13'(`CTS_FLOAT_KNEE_MV
        + `CTS_FLOAT_STEP_MV * 13'(float_voltage_code - `CTS_FLOAT_KNEE));
    assign nxt_float = (float_voltage_code < `CTS_FLOAT_KNEE) ? float_lin
        : (float_knee > `CTS_FLOAT_MAX_MV) ? `CTS_FLOAT_MAX_MV : float_knee;
    assign nxt_ceil = (charge_voltage_ceiling == 2'h0) ? 13'h0C80
        : (charge_voltage_ceiling == 2'h1) ? 13'h0D48
        : (charge_voltage_ceiling == 2'h2) ? 13'h0E74 : 13'h0ED8;
    assign nxt_fast = 11'(`CTS_FAST_STEP_MA * (11'(fast_current_code) + 11'h001));
    assign nxt_trk = (trickle_current_code == 2'h0) ? 7'h05
        : (trickle_current_code == 2'h1) ? 7'h0A
        : (trickle_current_code == 2'h2) ? 7'h14 : 7'h50;
    assign nxt_dead = (dead_battery_threshold == 2'h0) ? 12'h7D0
        : (dead_battery_threshold == 2'h1) ? 12'h9C4
        : (dead_battery_threshold == 2'h2) ? 12'hA28 : 12'hB54;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            float_mv <= 13'h0000;
            ceil_mv <= 13'h0000;
            fast_ma <= 11'h000;
            trickle_ma <= 7'h00;
            recharge_en <= 1'b0;
            recharge_delta_mv <= 9'h000;
            dead_mv <= 12'h000;
            weak_mv <= 12'h000;
        end else begin
            float_mv <= nxt_float;
            ceil_mv <= nxt_ceil;
            fast_ma <= nxt_fast;
            trickle_ma <= nxt_trk;
            recharge_en <= ~recharge_off;
            recharge_delta_mv <= 9'(`CTS_RCH_BASE_MV + `CTS_RCH_STEP_MV * 9'(recharge_delta_code));
            dead_mv <= nxt_dead;
            weak_mv <= 12'(`CTS_WEAK_BASE_MV + `CTS_WEAK_STEP_MV * 12'(weak_battery_threshold));
        end
    end
endmodule

// [cts_pkg.sv]
/*
 * Types shared by the charger threshold settings bank.
 * Assumes constants come from cts_regs.svh.
 */
package cts_pkg;
    // serial slave states, gray along the usual path
    typedef enum logic [2:0] {
        CTS_IDLE = 3'h0,
        CTS_ADDR = 3'h1,
        CTS_ADDR_ACK = 3'h3,
        CTS_RX = 3'h2,
        CTS_RX_ACK = 3'h6,
        CTS_TX = 3'h7,
        CTS_TX_ACK = 3'h5
    } cts_state_e;
endpackage

// [cts_regs.svh]
/*
 * Register map, field positions, reset values and decode constants of the
 * charger threshold settings bank.
 * Assumes the including file only needs `define constants.
 */
//
// Contract
// - float_voltage_code is bits [7:2] of termination register, resets 100011 (4.20 V).
// - termination settings register sits at address 0x03.
// - float codes 20 mV steps to 4.44 V; 110000 4.44, then 4.46, 4.48, 4.50 saturating.
// - charge_voltage_ceiling bits [1:0]: 3.2/3.4/3.7/3.8 V, read/write, resets 10.
// - fast_current_code bits [5:2] of 0x04, 50 mA base and step, resets 750 mA.
// - bits 7 and 6 of charge current register are unused and read-only.
// - trickle_current_code bits [1:0]: 5/10/20/80 mA, resets 10.
// - recharge_off bit 7 of 0x05 disables recharge, overrides threshold, resets 0.
// - recharge_delta_code bits [6:5]: 80/140/200/260 mV below float, resets 11.
// - dead_battery_threshold bits [4:3]: 2.0/2.5/2.6/2.9 V, resets 01.
// - weak_battery_threshold bits [2:0]: 2.7 V to 3.4 V in 100 mV, resets 011.
`ifndef CTS_REGS_SVH
`define CTS_REGS_SVH

`define CTS_ADDR_TERM 8'h03
`define CTS_ADDR_CURR 8'h04
`define CTS_ADDR_THR 8'h05

`define CTS_TERM_RESET 8'h8E
`define CTS_CURR_RESET 6'h3A
`define CTS_THR_RESET 8'h6B

`define CTS_FLOAT_MSB 7
`define CTS_FLOAT_LSB 2
`define CTS_CEIL_MSB 1
`define CTS_FAST_MSB 5
`define CTS_FAST_LSB 2
`define CTS_TRK_MSB 1
`define CTS_RCH_OFF_BIT 7
`define CTS_RCH_MSB 6
`define CTS_RCH_LSB 5
`define CTS_DEAD_MSB 4
`define CTS_DEAD_LSB 3
`define CTS_WEAK_MSB 2

`define CTS_FLOAT_BASE_MV 13'h0DAC
`define CTS_FLOAT_STEP_MV 13'h0014
`define CTS_FLOAT_KNEE 6'h30
`define CTS_FLOAT_KNEE_MV 13'h1158
`define CTS_FLOAT_MAX_MV 13'h1194
`define CTS_FAST_STEP_MA 11'h032
`define CTS_RCH_BASE_MV 9'h050
`define CTS_RCH_STEP_MV 9'h03C
`define CTS_WEAK_BASE_MV 12'hA8C
`define CTS_WEAK_STEP_MV 12'h064

`endif

// [cts_top.sv]
/*
 * Charger threshold settings bank: an I2C slave with a register pointer,
 * the three setting registers, and the decoder that drives the charger core.
 * Assumes SCL and SDA arrive asynchronously from pins and that SDA is an
 * open-drain wire pulled up outside; the slave never stretches SCL.
 */
`timescale 1ns/100ps
`include "cts_regs.svh"

module cts_top #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary slave address
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // serial pins
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // raw settings
    output logic [7:0] TERM_REG,
    output logic [7:0] CURR_REG,
    output logic [7:0] THR_REG,
    // decoded targets
    output logic [12:0] FLOAT_MV,
    output logic [12:0] CEIL_MV,
    output logic [10:0] FAST_MA,
    output logic [6:0] TRICKLE_MA,
    output logic RECHARGE_EN,
    output logic [8:0] RECHARGE_DELTA_MV,
    output logic [11:0] DEAD_MV,
    output logic [11:0] WEAK_MV
);
    // pin synchronisers and edge history
    logic scl_meta_ff;
    logic sda_meta_ff;
    logic scl_s_ff;
    logic sda_s_ff;
    logic scl_d_ff;
    logic sda_d_ff;

    // slave state
    cts_pkg::cts_state_e state_ff;
    cts_pkg::cts_state_e nxt_state;
    logic [7:0] sh_ff;
    logic [7:0] nxt_sh;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [7:0] ptr_ff;
    logic [7:0] nxt_ptr;
    logic rw_ff;
    logic nxt_rw;
    logic first_ff;
    logic nxt_first;
    logic nack_ff;
    logic nxt_nack;
    logic drive_ff;
    logic nxt_drive;

    // setting registers
    logic [7:0] term_ff;
    logic [5:0] curr_ff;
    logic [7:0] thr_ff;

    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic byte_done;
    logic wr_en;
    logic [7:0] rdata;

    // register pointer steps by one and wraps at the top
    function automatic logic [7:0] ptr_step(input logic [7:0] p);
        return 8'(p + 8'h01);
    endfunction

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            scl_meta_ff <= 1'b1;
            sda_meta_ff <= 1'b1;
            scl_s_ff <= 1'b1;
            sda_s_ff <= 1'b1;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_meta_ff <= SCL_IN;
            sda_meta_ff <= SDA_IN;
            scl_s_ff <= scl_meta_ff;
            sda_s_ff <= sda_meta_ff;
            scl_d_ff <= scl_s_ff;
            sda_d_ff <= sda_s_ff;
        end
    end

    assign start_det = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
    assign stop_det = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
    assign scl_rise = scl_s_ff & ~scl_d_ff;
    assign scl_fall = ~scl_s_ff & scl_d_ff;
    assign byte_done = (cnt_ff == 4'h8);

    // read mux; unmapped addresses and unused bits read zero
    assign rdata = (ptr_ff == `CTS_ADDR_TERM) ? term_ff
        : (ptr_ff == `CTS_ADDR_CURR) ? {2'b00, curr_ff}
        : (ptr_ff == `CTS_ADDR_THR) ? thr_ff : 8'h00;

    // data byte of a write, after the pointer byte
    assign wr_en = (state_ff == cts_pkg::CTS_RX) & scl_fall & byte_done & ~first_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_ptr = ptr_ff;
        nxt_rw = rw_ff;
        nxt_first = first_ff;
        nxt_nack = nack_ff;
        nxt_drive = drive_ff;
        if (start_det) begin
            nxt_state = cts_pkg::CTS_ADDR;
            nxt_cnt = 4'h0;
            nxt_drive = 1'b0;
        end else if (stop_det) begin
            nxt_state = cts_pkg::CTS_IDLE;
            nxt_drive = 1'b0;
        end else begin
            unique case (state_ff)
                cts_pkg::CTS_IDLE: begin
                    nxt_drive = 1'b0;
                end
                cts_pkg::CTS_ADDR, cts_pkg::CTS_RX: begin
                    if (scl_rise) begin
                        nxt_sh = {sh_ff[6:0], sda_s_ff};
                        nxt_cnt = 4'(cnt_ff + 4'h1);
                    end else if (scl_fall && byte_done) begin
                        if (state_ff == cts_pkg::CTS_RX) begin
                            nxt_state = cts_pkg::CTS_RX_ACK;
                            nxt_drive = 1'b1;
                            nxt_first = 1'b0;
                            if (first_ff) begin
                                nxt_ptr = sh_ff;
                            end else begin
                                nxt_ptr = ptr_step(ptr_ff);
                            end
                        end else if (sh_ff[7:1] == DEV_ADDR) begin
                            nxt_state = cts_pkg::CTS_ADDR_ACK;
                            nxt_rw = sh_ff[0];
                            nxt_drive = 1'b1;
                        end else begin
                            nxt_state = cts_pkg::CTS_IDLE;
                        end
                    end
                end
                cts_pkg::CTS_ADDR_ACK, cts_pkg::CTS_RX_ACK: begin
                    if (scl_fall) begin
                        nxt_cnt = 4'h0;
                        if (state_ff == cts_pkg::CTS_ADDR_ACK && rw_ff) begin
                            nxt_state = cts_pkg::CTS_TX;
                            nxt_sh = rdata;
                            nxt_drive = ~rdata[7];
                            nxt_ptr = ptr_step(ptr_ff);
                        end else begin
                            nxt_state = cts_pkg::CTS_RX;
                            nxt_drive = 1'b0;
                            if (state_ff == cts_pkg::CTS_ADDR_ACK) begin
                                nxt_first = 1'b1;
                            end
                        end
                    end
                end
                cts_pkg::CTS_TX: begin
                    if (scl_rise) begin
                        nxt_cnt = 4'(cnt_ff + 4'h1);
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            nxt_state = cts_pkg::CTS_TX_ACK;
                            nxt_drive = 1'b0;
                        end else begin
                            nxt_sh = {sh_ff[6:0], 1'b0};
                            nxt_drive = ~sh_ff[6];
                        end
                    end
                end
                cts_pkg::CTS_TX_ACK: begin
                    if (scl_rise) begin
                        nxt_nack = sda_s_ff;
                    end else if (scl_fall) begin
                        nxt_cnt = 4'h0;
                        if (nack_ff) begin
                            nxt_state = cts_pkg::CTS_IDLE;
                        end else begin
                            nxt_state = cts_pkg::CTS_TX;
                            nxt_sh = rdata;
                            nxt_drive = ~rdata[7];
                            nxt_ptr = ptr_step(ptr_ff);
                        end
                    end
                end
                default: begin
                    nxt_state = cts_pkg::CTS_IDLE;
                    nxt_drive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            state_ff <= cts_pkg::CTS_IDLE;
            sh_ff <= 8'h00;
            cnt_ff <= 4'h0;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            first_ff <= 1'b0;
            nack_ff <= 1'b0;
            drive_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            ptr_ff <= nxt_ptr;
            rw_ff <= nxt_rw;
            first_ff <= nxt_first;
            nack_ff <= nxt_nack;
            drive_ff <= nxt_drive;
        end
    end

    // setting registers
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            term_ff <= `CTS_TERM_RESET;
            curr_ff <= `CTS_CURR_RESET;
            thr_ff <= `CTS_THR_RESET;
        end else if (wr_en) begin
            if (ptr_ff == `CTS_ADDR_TERM) begin
                term_ff <= sh_ff;
            end
            if (ptr_ff == `CTS_ADDR_CURR) begin
                curr_ff <= sh_ff[5:0];
            end
            if (ptr_ff == `CTS_ADDR_THR) begin
                thr_ff <= sh_ff;
            end
        end
    end

    // open drain: only ever pulls low
    assign SDA_OUT = 1'b0;
    assign SDA_OE = drive_ff;
    assign TERM_REG = term_ff;
    assign CURR_REG = {2'b00, curr_ff};
    assign THR_REG = thr_ff;

    cts_decode u_decode (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .float_voltage_code(term_ff[`CTS_FLOAT_MSB:`CTS_FLOAT_LSB]),
        .charge_voltage_ceiling(term_ff[`CTS_CEIL_MSB:0]),
        .fast_current_code(curr_ff[`CTS_FAST_MSB:`CTS_FAST_LSB]),
        .trickle_current_code(curr_ff[`CTS_TRK_MSB:0]),
        .recharge_off(thr_ff[`CTS_RCH_OFF_BIT]),
        .recharge_delta_code(thr_ff[`CTS_RCH_MSB:`CTS_RCH_LSB]),
        .dead_battery_threshold(thr_ff[`CTS_DEAD_MSB:`CTS_DEAD_LSB]),
        .weak_battery_threshold(thr_ff[`CTS_WEAK_MSB:0]),
        .float_mv(FLOAT_MV),
        .ceil_mv(CEIL_MV),
        .fast_ma(FAST_MA),
        .trickle_ma(TRICKLE_MA),
        .recharge_en(RECHARGE_EN),
        .recharge_delta_mv(RECHARGE_DELTA_MV),
        .dead_mv(DEAD_MV),
        .weak_mv(WEAK_MV)
    );
endmodule

// [cts_top_monitor.sv]
/*
 * Checker for cts_top: each decoded target follows its setting code,
 * every register change is acknowledged on the serial data pin.
 * Assumes bind to cts_top, one clock, asynchronous active-low reset.
 */
`timescale 1ns/100ps

module cts_top_monitor (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // serial data pin
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    // settings
    input wire logic [7:0] TERM_REG,
    input wire logic [7:0] CURR_REG,
    input wire logic [7:0] THR_REG,
    // targets
    input wire logic [12:0] FLOAT_MV,
    input wire logic [12:0] CEIL_MV,
    input wire logic [10:0] FAST_MA,
    input wire logic [6:0] TRICKLE_MA,
    input wire logic RECHARGE_EN,
    input wire logic [8:0] RECHARGE_DELTA_MV,
    input wire logic [11:0] DEAD_MV,
    input wire logic [11:0] WEAK_MV
);
    localparam logic [12:0] CEIL_T [4] = '{13'h0C80, 13'h0D48, 13'h0E74, 13'h0ED8};
    localparam logic [6:0] TRK_T [4] = '{7'h05, 7'h0A, 7'h14, 7'h50};
    localparam logic [11:0] DEAD_T [4] = '{12'h7D0, 12'h9C4, 12'hA28, 12'hB54};
    logic live_ff;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    // targets lag reset release by one edge
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            live_ff <= 1'b0;
        end else begin
            live_ff <= 1'b1;
        end
    end

    function automatic logic [12:0] float_exp(input logic [5:0] c);
        return (c <= 6'h2F) ? 13'h0DAC + 13'h0014 * c : (c == 6'h30) ? 13'h1158 :
            (c == 6'h31) ? 13'h116C : (c == 6'h32) ? 13'h1180 : 13'h1194;
    endfunction

    float_map_a: assert property (live_ff |-> FLOAT_MV == float_exp($past(TERM_REG[7:2])))
        else $error("float target mismatch");
    ceil_map_a: assert property (live_ff |-> CEIL_MV == CEIL_T[$past(TERM_REG[1:0])])
        else $error("ceiling target mismatch");
    fast_map_a: assert property (live_ff |-> FAST_MA == 11'h032 * ($past(CURR_REG[5:2]) + 11'h001))
        else $error("fast current mismatch");
    curr_unused_a: assert property (CURR_REG[7:6] == 2'h0)
        else $error("unused current bits set");
    trickle_map_a: assert property (live_ff |-> TRICKLE_MA == TRK_T[$past(CURR_REG[1:0])])
        else $error("trickle current mismatch");
    recharge_en_a: assert property (live_ff |-> RECHARGE_EN == !$past(THR_REG[7]))
        else $error("recharge enable mismatch");
    delta_map_a: assert property (live_ff |-> RECHARGE_DELTA_MV == 9'h050 + 9'h03C * $past(THR_REG[6:5]))
        else $error("recharge delta mismatch");
    dead_map_a: assert property (live_ff |-> DEAD_MV == DEAD_T[$past(THR_REG[4:3])])
        else $error("dead threshold mismatch");
    weak_map_a: assert property (live_ff |-> WEAK_MV == 12'hA8C + 12'h064 * $past(THR_REG[2:0]))
        else $error("weak threshold mismatch");
    sda_pull_low_a: assert property (SDA_OUT == 1'b0)
        else $error("data pin driven high");
    write_ack_a: assert property (!$stable({TERM_REG, CURR_REG, THR_REG}) |-> $rose(SDA_OE))
        else $error("register changed without acknowledge");
endmodule

bind cts_top cts_top_monitor cts_top_monitor_i (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .TERM_REG(TERM_REG), .CURR_REG(CURR_REG), .THR_REG(THR_REG), .FLOAT_MV(FLOAT_MV),
    .CEIL_MV(CEIL_MV), .FAST_MA(FAST_MA), .TRICKLE_MA(TRICKLE_MA), .RECHARGE_EN(RECHARGE_EN),
    .RECHARGE_DELTA_MV(RECHARGE_DELTA_MV), .DEAD_MV(DEAD_MV), .WEAK_MV(WEAK_MV));

// [cts_top_tb.sv]
/*
 * Testbench for cts_top: an I2C master on the pins, checks of settings and targets.
 * Assumes SDA pulled up outside and no clock stretching by the slave.
 */
`timescale 1ns/100ps

module cts_top_tb;
    localparam logic [6:0] ADDR = 7'h2A;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic scl = 1'b1;
    logic sda_m = 1'b1;
    logic sda_out, sda_oe, rch_en;
    logic [7:0] term_reg, curr_reg, thr_reg;
    logic [12:0] float_mv, ceil_mv;
    logic [10:0] fast_ma;
    logic [6:0] trk_ma;
    logic [8:0] delta_mv;
    logic [11:0] dead_mv, weak_mv;
    int bad_count = 0;
    int total_checks = 0;
    wire sda_w = sda_m && !(sda_oe && !sda_out);

    cts_top cts_top_i (.CLK_SYS(clk_sys), .RESET_N(reset_n), .SCL_IN(scl), .SDA_IN(sda_w),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .TERM_REG(term_reg), .CURR_REG(curr_reg),
        .THR_REG(thr_reg), .FLOAT_MV(float_mv), .CEIL_MV(ceil_mv), .FAST_MA(fast_ma),
        .TRICKLE_MA(trk_ma), .RECHARGE_EN(rch_en), .RECHARGE_DELTA_MV(delta_mv),
        .DEAD_MV(dead_mv), .WEAK_MV(weak_mv));

    always #2 clk_sys = !clk_sys;

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic start();
        sda_m = 1'b1;
        tick(8);
        scl = 1'b1;
        tick(8);
        sda_m = 1'b0;
        tick(8);
        scl = 1'b0;
    endtask

    task automatic stop();
        sda_m = 1'b0;
        tick(8);
        scl = 1'b1;
        tick(8);
        sda_m = 1'b1;
        tick(8);
    endtask

    task automatic bit1(input logic b, output logic r);
        sda_m = b;
        tick(8);
        scl = 1'b1;
        tick(8);
        r = sda_w;
        scl = 1'b0;
    endtask

    // eight bits msb first, then the acknowledge bit
    task automatic xbyte(input logic [7:0] d, input logic m9, output logic [7:0] q, output logic n9);
        for (int i = 7; i >= 0; i--) bit1(d[i], q[i]);
        bit1(m9, n9);
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1, input logic two);
        logic [7:0] q;
        logic n;
        start();
        xbyte({ADDR, 1'b0}, 1'b1, q, n);
        chk(n, 1'b0);
        xbyte(ptr, 1'b1, q, n);
        chk(n, 1'b0);
        xbyte(d0, 1'b1, q, n);
        chk(n, 1'b0);
        if (two) begin
            xbyte(d1, 1'b1, q, n);
            chk(n, 1'b0);
        end
        stop();
    endtask

    task automatic rd(input logic [7:0] ptr, output logic [7:0] q0, output logic [7:0] q1);
        logic [7:0] q;
        logic n;
        start();
        xbyte({ADDR, 1'b0}, 1'b1, q, n);
        xbyte(ptr, 1'b1, q, n);
        start();
        xbyte({ADDR, 1'b1}, 1'b1, q, n);
        chk(n, 1'b0);
        xbyte(8'hFF, 1'b0, q0, n);
        xbyte(8'hFF, 1'b1, q1, n);
        stop();
    endtask

    task automatic s_reset();
        logic [7:0] a, b;
        chk(float_mv, 13'h1068);
        chk(fast_ma, 11'h2EE);
        chk(rch_en, 1'b1);
        rd(8'h03, a, b);
        chk(a, 8'h8E);
        chk(b, 8'h3A);
        rd(8'h05, a, b);
        chk(a, 8'h6B);
        chk(b, 8'h00);
    endtask

    task automatic s_float();
        logic [5:0] code [6] = '{6'h0F, 6'h2F, 6'h30, 6'h31, 6'h32, 6'h3F};
        logic [12:0] mv [6] = '{13'h0ED8, 13'h1158, 13'h1158, 13'h116C, 13'h1180, 13'h1194};
        logic [12:0] ceil [4] = '{13'h0C80, 13'h0D48, 13'h0E74, 13'h0ED8};
        for (int k = 0; k < 6; k++) begin
            wr(8'h03, {code[k], 2'(k)}, 8'h00, 1'b0);
            chk(term_reg, {code[k], 2'(k)});
            chk(float_mv, mv[k]);
            chk(ceil_mv, ceil[k % 4]);
        end
    endtask

    task automatic s_curr();
        logic [6:0] trk [4] = '{7'h05, 7'h0A, 7'h14, 7'h50};
        logic [7:0] a, b;
        logic [3:0] f;
        for (int k = 0; k < 4; k++) begin
            f = 4'(k * 5);
            wr(8'h04, {2'b11, f, 2'(k)}, 8'h00, 1'b0);
            chk(curr_reg, {2'b00, f, 2'(k)});
            chk(fast_ma, 11'h032 * (f + 11'h001));
            chk(trk_ma, trk[k]);
        end
        rd(8'h04, a, b);
        chk(a, 8'h3F);
    endtask

    task automatic s_thr();
        logic [11:0] dead [4] = '{12'h7D0, 12'h9C4, 12'hA28, 12'hB54};
        logic [2:0] i;
        for (int k = 0; k < 8; k++) begin
            i = 3'(k);
            wr(8'h05, {i[0], i[1:0], i[2:1], i}, 8'h00, 1'b0);
            chk(rch_en, !i[0]);
            chk(delta_mv, 9'h050 + 9'h03C * i[1:0]);
            chk(dead_mv, dead[i[2:1]]);
            chk(weak_mv, 12'hA8C + 12'h064 * i);
        end
    endtask

    // foreign address ignored, unmapped byte discarded and read as zero
    task automatic s_refuse();
        logic [7:0] a, b;
        logic n;
        start();
        xbyte({7'h2B, 1'b0}, 1'b1, a, n);
        chk(n, 1'b1);
        stop();
        wr(8'h05, 8'h80, 8'h55, 1'b1);
        rd(8'h05, a, b);
        chk(a, 8'h80);
        chk(b, 8'h00);
        chk(rch_en, 1'b0);
    endtask

    initial begin
        tick(100000);
        bad_count++;
        conclude();
    end

    initial begin
        tick(10);
        reset_n = 1'b1;
        tick(4);
        s_reset();
        s_float();
        s_curr();
        s_thr();
        s_refuse();
        reset_n = 1'b0;
        tick(10);
        reset_n = 1'b1;
        tick(4);
        s_reset();
        conclude();
    end
endmodule
